/* File: inc/dog_supply_pkg.sv */
// Purpose: Shared constants for the watchdog, supply-fail reset and power mode register.
// Assumes: clk_i is the oscillator clock; one machine cycle is twelve oscillator periods.
// Notes: Addresses are special-function register addresses on the CPU's internal bus.
package dog_supply_pkg;
	// ****************************************
	// Register addresses and reset values
	// ****************************************
	localparam logic [7:0] PMC_ADDR = 8'h87;
	localparam logic [7:0] DCR_ADDR = 8'hE6;
	localparam logic [7:0] PMC_RESET = 8'h00;
	localparam logic [7:0] DCR_RESET = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PMC_IDLE_BIT = 0;
	localparam int PMC_PD_BIT = 1;
	localparam int PMC_FLAG_LO_BIT = 2;
	localparam int PMC_FLAG_HI_BIT = 3;
	localparam int PMC_SUPPLY_FAIL_ENABLE_BIT = 4;
	localparam int PMC_BAUD_BIT = 7;
	localparam int DCR_RUN_BIT = 7;
	localparam int DCR_INT_LSB = 0;
	localparam int DCR_INT_W = 4;

	// ****************************************
	// Timing counts
	// ****************************************
	localparam logic [3:0] OSC_PER_MC = 4'hC;
	localparam int PRESCALE_W = 17;
	localparam int PRESCALE_LEN = 131072;
	localparam int HOLD_MC = 2;
	localparam logic [4:0] HOLD_CYCLES = 5'(HOLD_MC * 12);
	localparam int GLITCH_SAMPLES = 3;
endpackage

/* File: rtl/dog_supply_reset.sv */
// Purpose: Watchdog, supply-fail reset and power mode control register of the CPU.
// Assumes: Synchronous active-low external reset; low_supply_i is asynchronous.
// Notes: sys_rst_o is the internal reset fed back to the CPU and to this block.
//
// Functional notes
// - Prescaler of 17 bits fed at oscillator/12
// - Counter decrements once per 12*131072 periods
// - Interval code zero means sixteen, else n
// - Control write reloads; underflow gives system reset
// - Enabled watchdog stops only by system reset
// - Watchdog frozen in idle or power-down
// - Enabled low supply holds internal reset asserted
// - Reset held two machine cycles after recovery
// - Supply pulses under three periods are ignored
// - Supply-fail reset needs enable bit 4 set
// - Supply-fail reset suppressed in idle or power-down
// - Enable bit cleared only by external reset
// - Bit 1 enters power-down; reset clears it
// - Bit 0 enters idle; interrupt or reset clears
// - Power-down wins when both bits written
// - Bits 3 and 2 are plain software flags
// - Bit 7 drives serial baud doubler
// - Control register: run bit 7, interval 3..0
`timescale 1ns/100ps
module dog_supply_reset #(
	parameter int PRESCALE_LEN = dog_supply_pkg::PRESCALE_LEN
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic intr_i,
	input wire logic low_supply_i,
	output logic [7:0] sfr_rdata_o,
	output logic sys_rst_o,
	output logic idle_mode_o,
	output logic powerdown_mode_o,
	output logic baud_doubler_o
);
	localparam logic [16:0] PRESC_LAST = 17'(PRESCALE_LEN - 1);

	// ****************************************
	// Register bus decode
	// ****************************************
	logic pmc_wr;
	logic dcr_wr;
	assign pmc_wr = sfr_wr_i && (sfr_addr_i == dog_supply_pkg::PMC_ADDR);
	assign dcr_wr = sfr_wr_i && (sfr_addr_i == dog_supply_pkg::DCR_ADDR);

	// ****************************************
	// Low supply synchroniser and glitch filter
	// ****************************************
	logic low_meta_reg;
	logic low_sync_reg;
	logic [1:0] low_hist_reg;
	logic [1:0] low_hist_next;
	logic supply_low_filt;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			low_meta_reg <= 1'b0;
			low_sync_reg <= 1'b0;
			low_hist_reg <= 2'h0;
		end else begin
			low_meta_reg <= low_supply_i;
			low_sync_reg <= low_meta_reg;
			low_hist_reg <= low_hist_next;
		end
	end

	always_comb begin
		low_hist_next = {low_hist_reg[0], low_sync_reg};
	end

	// Three agreeing samples; shorter pulses never reach the reset logic
	assign supply_low_filt = low_sync_reg && (&low_hist_reg);

	// ****************************************
	// Power mode control register
	// ****************************************
	logic idle_reg, idle_next;
	logic pd_reg, pd_next;
	logic flag_lo_reg, flag_lo_next;
	logic flag_hi_reg, flag_hi_next;
	logic supply_fail_enable_reg, supply_fail_enable_next;
	logic baud_reg, baud_next;
	logic int_rst;
	logic frozen;

	assign frozen = idle_reg || pd_reg;

	always_comb begin
		idle_next = idle_reg;
		pd_next = pd_reg;
		flag_lo_next = flag_lo_reg;
		flag_hi_next = flag_hi_reg;
		supply_fail_enable_next = supply_fail_enable_reg;
		baud_next = baud_reg;
		if (int_rst) begin
			// Internal reset keeps the enable so protection has no gap
			idle_next = 1'b0;
			pd_next = 1'b0;
			flag_lo_next = 1'b0;
			flag_hi_next = 1'b0;
			baud_next = 1'b0;
		end else if (pmc_wr) begin
			pd_next = sfr_wdata_i[dog_supply_pkg::PMC_PD_BIT];
			// Power-down has precedence over idle in one write
			idle_next = sfr_wdata_i[dog_supply_pkg::PMC_IDLE_BIT]
				&& !sfr_wdata_i[dog_supply_pkg::PMC_PD_BIT];
			flag_lo_next = sfr_wdata_i[dog_supply_pkg::PMC_FLAG_LO_BIT];
			flag_hi_next = sfr_wdata_i[dog_supply_pkg::PMC_FLAG_HI_BIT];
			supply_fail_enable_next = supply_fail_enable_reg || sfr_wdata_i[dog_supply_pkg::PMC_SUPPLY_FAIL_ENABLE_BIT];
			baud_next = sfr_wdata_i[dog_supply_pkg::PMC_BAUD_BIT];
		end else if (intr_i) begin
			idle_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			idle_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_IDLE_BIT];
			pd_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_PD_BIT];
			flag_lo_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_FLAG_LO_BIT];
			flag_hi_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_FLAG_HI_BIT];
			supply_fail_enable_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_SUPPLY_FAIL_ENABLE_BIT];
			baud_reg <= dog_supply_pkg::PMC_RESET[dog_supply_pkg::PMC_BAUD_BIT];
		end else begin
			idle_reg <= idle_next;
			pd_reg <= pd_next;
			flag_lo_reg <= flag_lo_next;
			flag_hi_reg <= flag_hi_next;
			supply_fail_enable_reg <= supply_fail_enable_next;
			baud_reg <= baud_next;
		end
	end

	// ****************************************
	// Watchdog prescaler and counter
	// ****************************************
	logic run_reg, run_next;
	logic [3:0] interval_reg, interval_next;
	logic [3:0] div_reg, div_next;
	logic [16:0] presc_reg, presc_next;
	logic [3:0] cnt_reg, cnt_next;
	logic dog_tick;
	logic dog_expire;

	// Code zero loads fifteen so sixteen ticks pass before underflow
	function automatic logic [3:0] interval_load(input logic [3:0] code);
		interval_load = (code == 4'h0) ? 4'hF : 4'(code - 4'h1);
	endfunction

	assign dog_tick = run_reg && !frozen && (div_reg == 4'(dog_supply_pkg::OSC_PER_MC - 4'h1))
		&& (presc_reg == PRESC_LAST);
	assign dog_expire = dog_tick && (cnt_reg == 4'h0);

	always_comb begin
		run_next = run_reg;
		interval_next = interval_reg;
		div_next = div_reg;
		presc_next = presc_reg;
		cnt_next = cnt_reg;
		if (int_rst) begin
			run_next = 1'b0;
			interval_next = dog_supply_pkg::DCR_RESET[3:0];
			div_next = 4'h0;
			presc_next = 17'h00000;
			cnt_next = interval_load(dog_supply_pkg::DCR_RESET[3:0]);
		end else if (dcr_wr) begin
			// Writing zero to the run bit never stops a running watchdog
			run_next = run_reg || sfr_wdata_i[dog_supply_pkg::DCR_RUN_BIT];
			interval_next = sfr_wdata_i[dog_supply_pkg::DCR_INT_LSB +: dog_supply_pkg::DCR_INT_W];
			div_next = 4'h0;
			presc_next = 17'h00000;
			cnt_next = interval_load(sfr_wdata_i[dog_supply_pkg::DCR_INT_LSB +:
				dog_supply_pkg::DCR_INT_W]);
		end else if (run_reg && !frozen) begin
			if (div_reg == 4'(dog_supply_pkg::OSC_PER_MC - 4'h1)) begin
				div_next = 4'h0;
				presc_next = (presc_reg == PRESC_LAST) ? 17'h00000 : 17'(presc_reg + 17'h1);
				if (dog_tick) begin
					cnt_next = 4'(cnt_reg - 4'h1);
				end
			end else begin
				div_next = 4'(div_reg + 4'h1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			run_reg <= dog_supply_pkg::DCR_RESET[dog_supply_pkg::DCR_RUN_BIT];
			interval_reg <= dog_supply_pkg::DCR_RESET[3:0];
			div_reg <= 4'h0;
			presc_reg <= 17'h00000;
			cnt_reg <= interval_load(dog_supply_pkg::DCR_RESET[3:0]);
		end else begin
			run_reg <= run_next;
			interval_reg <= interval_next;
			div_reg <= div_next;
			presc_reg <= presc_next;
			cnt_reg <= cnt_next;
		end
	end

	// ****************************************
	// Internal reset generation
	// ****************************************
	logic pfr_trip;
	logic [4:0] hold_reg, hold_next;
	logic rst_reg, rst_next;

	// Idle or power-down suppresses supply-fail reset
	assign pfr_trip = supply_fail_enable_reg && !frozen && supply_low_filt;
	assign int_rst = rst_reg;

	always_comb begin
		hold_next = hold_reg;
		rst_next = 1'b0;
		if (pfr_trip || dog_expire) begin
			hold_next = dog_supply_pkg::HOLD_CYCLES;
			rst_next = 1'b1;
		end else if (hold_reg != 5'h00) begin
			hold_next = 5'(hold_reg - 5'h01);
			rst_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			hold_reg <= 5'h00;
			rst_reg <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			rst_reg <= rst_next;
		end
	end

	// ****************************************
	// Read data and outputs
	// ****************************************
	logic [7:0] rdata_reg, rdata_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (sfr_rd_i && (sfr_addr_i == dog_supply_pkg::PMC_ADDR)) begin
			rdata_next = {baud_reg, 2'h0, supply_fail_enable_reg, flag_hi_reg, flag_lo_reg, pd_reg, idle_reg};
		end else if (sfr_rd_i && (sfr_addr_i == dog_supply_pkg::DCR_ADDR)) begin
			rdata_next = {run_reg, 3'h0, interval_reg};
		end else if (sfr_rd_i) begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign sfr_rdata_o = rdata_reg;
	assign sys_rst_o = rst_reg;
	assign idle_mode_o = idle_reg;
	assign powerdown_mode_o = pd_reg;
	assign baud_doubler_o = baud_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_dcr_write_code5;
		dcr_wr && !int_rst && (sfr_wdata_i[3:0] == 4'h5);
	endsequence
	sequence s_rst_window;
		sys_rst_o [*8];
	endsequence

	AST_RELOAD_LOAD: assert property (s_dcr_write_code5 |=> (cnt_reg == 4'h4)
		&& (presc_reg == 17'h00000) && (div_reg == 4'h0))
		else $error("Reload did not load interval or clear prescaler");
	AST_CODE_ZERO: assert property (dcr_wr && !int_rst && (sfr_wdata_i[3:0] == 4'h0)
		|=> cnt_reg == 4'hF)
		else $error("Interval code zero did not give sixteen ticks");
	AST_UNDERFLOW_RST: assert property (dog_expire |=> s_rst_window)
		else $error("Watchdog underflow did not hold system reset");
	AST_RUN_STICKY: assert property (run_reg && !int_rst |=> run_reg)
		else $error("Watchdog stopped without system reset");
	AST_FROZEN: assert property (frozen && !dcr_wr && !int_rst
		|=> $stable(presc_reg) && $stable(cnt_reg) && $stable(div_reg))
		else $error("Watchdog advanced in low power mode");
	AST_TICK_SPACING: assert property (dog_tick |=> !dog_tick [*8])
		else $error("Watchdog ticks too close together");
	AST_PFR_ASSERT: assert property (pfr_trip |=> sys_rst_o && (hold_reg == 5'h18))
		else $error("Supply fail did not assert reset");
	AST_PFR_HOLD: assert property (sys_rst_o && !pfr_trip && !dog_expire && (hold_reg > 5'h01)
		|=> sys_rst_o && (hold_reg == $past(hold_reg) - 5'h01))
		else $error("Reset released before two machine cycles");
	AST_GLITCH: assert property (supply_low_filt |-> $past(low_sync_reg)
		&& $past(low_sync_reg, 2))
		else $error("Short supply pulse passed the filter");
	AST_PFR_ENABLE: assert property (!supply_fail_enable_reg |-> !pfr_trip)
		else $error("Supply fail reset acted while disabled");
	AST_PFR_SUPPRESS: assert property (frozen && supply_low_filt && !dog_expire
		&& (hold_reg == 5'h00) |=> !sys_rst_o)
		else $error("Supply fail reset acted in low power mode");
	AST_SUPPLY_FAIL_ENABLE_STICKY: assert property (supply_fail_enable_reg |=> supply_fail_enable_reg)
		else $error("Supply fail enable was cleared internally");
	AST_PD_WINS: assert property (pmc_wr && !int_rst && (sfr_wdata_i[1:0] == 2'h3)
		|=> powerdown_mode_o && !idle_mode_o)
		else $error("Idle taken over power-down");
	AST_IDLE_WAKE: assert property (idle_reg && intr_i && !pmc_wr |=> !idle_mode_o)
		else $error("Interrupt did not end idle");
	AST_RST_CLEARS_PD: assert property (int_rst |=> !powerdown_mode_o && !idle_mode_o)
		else $error("Reset did not clear power modes");
endmodule

/* File: verif/test_dog_supply_reset.sv */
// Purpose: Self-checking bench for the watchdog, supply-fail reset and power register.
// Assumes: PRESCALE_LEN shortened to 16, so one watchdog tick is 192 clocks.
// Notes: Inputs move on the falling edge; an integer model or a fixed 00 predicts every read.
`timescale 1ns/100ps
module test_dog_supply_reset;
	localparam int PLEN = 16;
	localparam int TICK = 12 * PLEN;
	localparam logic [7:0] PMC = dog_supply_pkg::PMC_ADDR;
	localparam logic [7:0] DCR = dog_supply_pkg::DCR_ADDR;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic sfr_wr_i = 1'b0;
	logic sfr_rd_i = 1'b0;
	logic intr_i = 1'b0;
	logic low_supply_i = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic sys_rst_o;
	logic idle_mode_o;
	logic powerdown_mode_o;
	logic baud_doubler_o;
	int n_fail = 0;
	int checks = 0;
	int pmc_m = 0;
	int dcr_m = 0;
	int n;
	logic bad;
	logic [15:0] lfsr = 16'hE89E;

	dog_supply_reset #(.PRESCALE_LEN(PLEN)) u_dog_supply_reset (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .intr_i(intr_i),
		.low_supply_i(low_supply_i), .sfr_rdata_o(sfr_rdata_o), .sys_rst_o(sys_rst_o),
		.idle_mode_o(idle_mode_o), .powerdown_mode_o(powerdown_mode_o),
		.baud_doubler_o(baud_doubler_o));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic stop_test();
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Model keeps the enable bit sticky and lets power-down beat idle
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
		if (a == PMC) begin
			pmc_m = (d & 8'h9F) | (pmc_m & 8'h10);
			if (d[1]) pmc_m = pmc_m & 8'hFE;
		end else if (a == DCR) begin
			dcr_m = (d & 8'h8F) | (dcr_m & 8'h80);
		end
	endtask

	task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_i);
		sfr_rd_i = 1'b0;
		check_byte("read data", exp, sfr_rdata_o);
	endtask

	task automatic wake();
		@(negedge clk_i);
		intr_i = 1'b1;
		@(negedge clk_i);
		intr_i = 1'b0;
		pmc_m = pmc_m & 8'hFE;
	endtask

	// Bounded wait; running out ends the run as a failure
	task automatic wait_rst(input logic lvl, input int max);
		n = 0;
		while (sys_rst_o !== lvl) begin
			@(negedge clk_i);
			n++;
			if (n > max) begin
				check_bit("reset wait", lvl, sys_rst_o);
				stop_test();
			end
		end
	endtask

	task automatic hold_rst(input logic lvl, input int cyc);
		bad = 1'b0;
		repeat (cyc) begin
			@(negedge clk_i);
			if (sys_rst_o !== lvl) bad = 1'b1;
		end
		check_bit("reset level held", 1'b0, bad);
	endtask

	task automatic pulse_low(input int cyc);
		@(negedge clk_i);
		low_supply_i = 1'b1;
		repeat (cyc) @(negedge clk_i);
		low_supply_i = 1'b0;
	endtask

	task automatic sys_model();
		pmc_m = pmc_m & 8'h10;
		dcr_m = 0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(negedge clk_i);
		rst_b_i = 1'b1;
		sfr_read(PMC, 8'h00);
		sfr_read(DCR, 8'h00);
		repeat (4) begin
			lfsr = lfsr_next(lfsr);
			sfr_write(PMC, lfsr[7:0] & 8'h8C);
			sfr_read(PMC, pmc_m[7:0]);
			check_bit("baud doubler", pmc_m[7], baud_doubler_o);
		end
		sfr_write(PMC, 8'h01);
		check_bit("idle", 1'b1, idle_mode_o);
		wake();
		check_bit("idle", 1'b0, idle_mode_o);
		for (int c = 0; c < 16; c++) begin
			sfr_write(DCR, 8'h80 | 8'(c));
			sfr_read(DCR, dcr_m[7:0]);
			wait_rst(1'b1, (c == 0 ? 16 : c) * TICK + 8);
			check_bit("dog interval", 1'b1, n >= (c == 0 ? 16 : c) * TICK - 8);
			sys_model();
			wait_rst(1'b0, 40);
			sfr_read(DCR, 8'h00);
		end
		sfr_read(PMC, pmc_m[7:0]);
		hold_rst(1'b0, 2 * TICK);
		sfr_write(DCR, 8'h81);
		repeat (100) @(negedge clk_i);
		sfr_write(DCR, 8'h01);
		sfr_write(PMC, 8'h01);
		hold_rst(1'b0, 300);
		wake();
		wait_rst(1'b1, TICK);
		check_bit("frozen count", 1'b1, n >= TICK - 12);
		sys_model();
		wait_rst(1'b0, 40);
		pulse_low(10);
		hold_rst(1'b0, 40);
		// Bench supply is taken as nominal, so setting the enable is allowed
		sfr_write(PMC, 8'h10);
		sfr_write(PMC, 8'h00);
		sfr_read(PMC, pmc_m[7:0]);
		pulse_low(2);
		hold_rst(1'b0, 40);
		@(negedge clk_i);
		low_supply_i = 1'b1;
		wait_rst(1'b1, 10);
		hold_rst(1'b1, 30);
		low_supply_i = 1'b0;
		hold_rst(1'b1, 24);
		wait_rst(1'b0, 20);
		sys_model();
		sfr_read(PMC, pmc_m[7:0]);
		sfr_write(PMC, 8'h13);
		check_bit("power-down", 1'b1, powerdown_mode_o);
		check_bit("idle", 1'b0, idle_mode_o);
		sfr_read(PMC, pmc_m[7:0]);
		// Previous read left nonzero data, so an unmapped read must clear it
		sfr_read(8'h55, 8'h00);
		pulse_low(10);
		hold_rst(1'b0, 40);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		check_bit("power-down", 1'b0, powerdown_mode_o);
		sfr_read(PMC, 8'h00);
		stop_test();
	end
endmodule
